// [src/subtract_swap_skip_pkg.sv]
package subtract_swap_skip_pkg;

    localparam int DATA_W            = 8;
    localparam int BIT_IDX_W         = 3;
    localparam int FLAG_W            = 6;
    localparam int APB_ADDR_W        = 8;
    localparam int APB_DATA_W        = 32;
    localparam int MEM_DEPTH_DEFAULT = 64;

    // register byte offsets
    localparam logic [APB_ADDR_W-1:0] REG_INSTR    = 8'h00;
    localparam logic [APB_ADDR_W-1:0] REG_WREG     = 8'h04;
    localparam logic [APB_ADDR_W-1:0] REG_MEM_ADDR = 8'h08;
    localparam logic [APB_ADDR_W-1:0] REG_MEM_DATA = 8'h0c;
    localparam logic [APB_ADDR_W-1:0] REG_STATUS   = 8'h10;
    localparam logic [APB_ADDR_W-1:0] REG_CYCLES   = 8'h14;

    // instruction word fields
    localparam int INSTR_OP_LSB  = 0;
    localparam int INSTR_BIT_LSB = 4;
    localparam int INSTR_IMM_LSB = 8;

    // status word fields
    localparam int FLAG_NULL        = 0;
    localparam int FLAG_BORROW_NOT  = 1;
    localparam int FLAG_HALF_BORROW = 2;
    localparam int FLAG_SIGNED_WRAP = 3;
    localparam int FLAG_SIGNED_BORR = 4;
    localparam int FLAG_CHAIN_NULL  = 5;
    localparam int STATUS_BUSY_BIT  = 8;
    localparam int STATUS_SKIP_BIT  = 9;

    // reset values
    localparam logic [DATA_W-1:0] WREG_RESET  = 8'h00;
    localparam logic [FLAG_W-1:0] FLAGS_RESET = 6'h00;

    // instruction cycle timing
    localparam int PCLK_PERIOD_NS    = 5;
    localparam int INSTR_CYCLE_NS    = 20;
    localparam int INSTR_CYCLE_PCLKS = INSTR_CYCLE_NS / PCLK_PERIOD_NS;

    typedef enum logic [2:0] {
        op_minus_into_wreg,
        op_minus_into_memory,
        op_minus_immediate,
        op_nibble_exchange,
        op_nibble_exchange_to_wreg,
        op_skip_if_null,
        op_load_and_skip_if_null,
        op_skip_if_bit_clear
    } opcode_type;

    typedef enum logic [1:0] {
        st_idle,
        st_execute,
        st_dummy
    } state_type;

endpackage : subtract_swap_skip_pkg

// [src/minus_if.sv]
`timescale 1ns/10ps
interface minus_if;
    import subtract_swap_skip_pkg::*;
    logic [DATA_W-1:0] minuend;
    logic [DATA_W-1:0] subtrahend;
    logic [DATA_W-1:0] difference;
    logic [FLAG_W-1:0] flags;
    modport calc (input minuend, input subtrahend, output difference, output flags);
    modport user (output minuend, output subtrahend, input difference, input flags);
endinterface : minus_if

// [src/minus_flags.sv]
`timescale 1ns/10ps
module minus_flags
    import subtract_swap_skip_pkg::*;
(
    minus_if.calc m
);
    logic [DATA_W:0]   wide;
    logic              wrap;
    logic              is_null;

    assign wide       = {1'b0, m.minuend} - {1'b0, m.subtrahend};
    assign m.difference = wide[DATA_W-1:0];
    assign is_null    = (wide[DATA_W-1:0] == '0);
    // signed wrap: operands differ in sign and result sign differs from minuend
    assign wrap       = (m.minuend[DATA_W-1] ^ m.subtrahend[DATA_W-1])
                      & (wide[DATA_W-1] ^ m.minuend[DATA_W-1]);

    always_comb begin
        m.flags                   = '0;
        m.flags[FLAG_NULL]        = is_null;                                   // see RULE3
        m.flags[FLAG_BORROW_NOT]  = ~wide[DATA_W];                             // see RULE2
        m.flags[FLAG_HALF_BORROW] = (m.minuend[3:0] >= m.subtrahend[3:0]);     // see RULE3
        m.flags[FLAG_SIGNED_WRAP] = wrap;                                      // see RULE3
        m.flags[FLAG_SIGNED_BORR] = wrap ^ wide[DATA_W-1];                     // see RULE3
        // a lone subtraction has no earlier byte to chain with
        m.flags[FLAG_CHAIN_NULL]  = is_null;                                   // see RULE3
    end

endmodule : minus_flags

// [src/subtract_swap_skip_exec.sv]
// Summary of operation
// RULE1 - memory minus: wreg minus byte into memory
// RULE2 - borrow_not flag clear when difference negative
// RULE3 - subtraction updates all six arithmetic flags
// RULE4 - immediate minus: wreg minus constant into wreg
// RULE5 - swap memory nibbles in place, flags kept
// RULE6 - swapped memory byte into wreg, flags kept
// RULE7 - skip next instruction when byte zero
// RULE8 - skip-type instructions take two instruction cycles
// RULE9 - copy byte to wreg, skip if zero
// RULE10 - skip next when selected bit is zero
// RULE11 - eight-bit data, bit index zero to seven
//
// Chosen here: the APB register port and the placing of the registers.
`timescale 1ns/10ps
module subtract_swap_skip_exec
    import subtract_swap_skip_pkg::*;
#(
    parameter int MEM_DEPTH    = MEM_DEPTH_DEFAULT,
    parameter int CYCLE_PCLKS  = INSTR_CYCLE_PCLKS
)(
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [APB_ADDR_W-1:0] paddr,
    input  wire logic [APB_DATA_W-1:0] pwdata,
    input  wire logic [3:0]            pstrb,
    output logic                       pready,
    output logic [APB_DATA_W-1:0]      prdata,
    output logic                       pslverr
);
    localparam int ADDR_W = (MEM_DEPTH > 1) ? $clog2(MEM_DEPTH) : 1;
    localparam int DIV_W  = (CYCLE_PCLKS > 1) ? $clog2(CYCLE_PCLKS) : 1;

    if (MEM_DEPTH < 2 || MEM_DEPTH > 256) begin : g_bad_depth
        $error("MEM_DEPTH must lie between 2 and 256");
    end
    if (CYCLE_PCLKS < 1) begin : g_bad_div
        $error("CYCLE_PCLKS must be at least 1");
    end

    // data memory, one byte per location
    logic [DATA_W-1:0]    mem [MEM_DEPTH];                  // see RULE11

    logic [DATA_W-1:0]    wreg_q;
    logic [FLAG_W-1:0]    flags_q;
    logic [ADDR_W-1:0]    addr_q;
    opcode_type           op_q;
    logic [BIT_IDX_W-1:0] bit_q;
    logic [DATA_W-1:0]    imm_q;
    state_type            state_q;
    logic                 skip_q;
    logic [31:0]          cycles_q;
    logic [DIV_W-1:0]     div_q;
    logic                 tick;
    logic                 pready_q;
    logic                 pslverr_q;
    logic [APB_DATA_W-1:0] prdata_q;

    minus_if alu ();

    minus_flags u_minus (
        .m (alu.calc)
    );

    // instruction cycle enable
    assign tick = (div_q == DIV_W'(CYCLE_PCLKS - 1));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_q <= '0;
        end else if (tick) begin
            div_q <= '0;
        end else begin
            div_q <= div_q + 1'b1;
        end
    end

    // operand selection and decode
    wire logic [DATA_W-1:0] mem_rd     = mem[addr_q];
    wire logic [DATA_W-1:0] mem_swap   = {mem_rd[3:0], mem_rd[7:4]};
    wire logic              use_imm    = (op_q == op_minus_immediate);
    wire logic              is_sub     = (op_q == op_minus_into_wreg)
                                       | (op_q == op_minus_into_memory)
                                       | use_imm;
    wire logic              is_skip    = (op_q == op_skip_if_null)
                                       | (op_q == op_load_and_skip_if_null)
                                       | (op_q == op_skip_if_bit_clear);
    wire logic              byte_null  = (mem_rd == '0);
    wire logic              bit_clear  = ~mem_rd[bit_q];                     // see RULE11
    wire logic              skip_cond  = (op_q == op_skip_if_bit_clear) ? bit_clear   // see RULE10
                                                                        : byte_null;  // see RULE7
    wire logic              exec_now   = (state_q == st_execute) & tick;
    wire logic              busy       = (state_q != st_idle);

    assign alu.minuend    = wreg_q;
    assign alu.subtrahend = use_imm ? imm_q : mem_rd;                        // see RULE4

    // bus decode; the access-phase cycle after the access is accepted completes it
    wire logic              acc_phase  = psel & penable;
    wire logic              rd_status  = ~pwrite & (paddr == REG_STATUS);
    // only the status register may be read while an instruction is in flight
    wire logic              stall      = busy & ~rd_status;
    wire logic              accept     = acc_phase & ~pready_q & ~stall;
    wire logic              complete   = acc_phase & pready_q;
    wire logic              wr_done    = complete & pwrite & ~pslverr_q & pstrb[0];
    wire logic              hit_instr  = (paddr == REG_INSTR);
    wire logic              hit_wreg   = (paddr == REG_WREG);
    wire logic              hit_addr   = (paddr == REG_MEM_ADDR);
    wire logic              hit_data   = (paddr == REG_MEM_DATA);
    wire logic              hit_stat   = (paddr == REG_STATUS);
    wire logic              hit_cyc    = (paddr == REG_CYCLES);
    wire logic              mapped     = hit_instr | hit_wreg | hit_addr
                                       | hit_data | hit_stat | hit_cyc;
    wire logic              start      = wr_done & hit_instr;

    wire logic [APB_DATA_W-1:0] status_word = {22'h000000, skip_q, busy, 2'b00, flags_q};
    wire logic [APB_DATA_W-1:0] instr_word  = {16'h0000, imm_q, 1'b0, bit_q, 1'b0, op_q};
    wire logic [APB_DATA_W-1:0] rd_word =
        hit_instr ? instr_word :
        hit_wreg  ? {24'h000000, wreg_q} :
        hit_addr  ? APB_DATA_W'(addr_q) :
        hit_data  ? {24'h000000, mem_rd} :
        hit_stat  ? status_word :
        hit_cyc   ? cycles_q : 32'h00000000;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= '0;
        end else if (accept) begin
            pready_q  <= 1'b1;
            pslverr_q <= ~mapped;
            prdata_q  <= pwrite ? 32'h00000000 : rd_word;
        end else begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
        end
    end

    assign pready  = pready_q;
    assign prdata  = prdata_q;
    assign pslverr = pslverr_q;

    // instruction word; only taken while idle, since stall holds the bus
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            op_q  <= op_minus_into_wreg;
            bit_q <= '0;
            imm_q <= '0;
        end else if (start) begin
            op_q  <= opcode_type'(pwdata[INSTR_OP_LSB +: 3]);
            bit_q <= pwdata[INSTR_BIT_LSB +: BIT_IDX_W];
            imm_q <= pwdata[INSTR_IMM_LSB +: DATA_W];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            addr_q <= '0;
        end else if (wr_done & hit_addr) begin
            addr_q <= pwdata[ADDR_W-1:0];
        end
    end

    // execution sequencer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= st_idle;
        end else begin
            unique case (state_q)
                st_idle: begin
                    if (start) begin
                        state_q <= st_execute;
                    end
                end
                st_execute: begin
                    if (tick) begin
                        // the dummy cycle stands in for the fetch behind a skip
                        state_q <= is_skip ? st_dummy : st_idle;   // see RULE8
                    end
                end
                st_dummy: begin
                    if (tick) begin
                        state_q <= st_idle;                          // see RULE8
                    end
                end
            endcase
        end
    end

    // skip outcome stays until the next instruction starts
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            skip_q <= 1'b0;
        end else if (exec_now & is_skip) begin
            skip_q <= skip_cond;                         // see RULE7 see RULE9 see RULE10
        end else if (start) begin
            skip_q <= 1'b0;
        end
    end

    // instruction cycles spent, wraps silently
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cycles_q <= '0;
        end else if (tick & busy) begin
            cycles_q <= cycles_q + 1'b1;
        end
    end

    // working register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wreg_q <= WREG_RESET;
        end else if (exec_now) begin
            unique case (op_q)
                op_minus_into_wreg:         wreg_q <= alu.difference;
                op_minus_immediate:         wreg_q <= alu.difference;   // see RULE4
                op_nibble_exchange_to_wreg: wreg_q <= mem_swap;         // see RULE6
                op_load_and_skip_if_null:   wreg_q <= mem_rd;           // see RULE9
                default:                    wreg_q <= wreg_q;           // see RULE1
            endcase
        end else if (wr_done & hit_wreg) begin
            wreg_q <= pwdata[DATA_W-1:0];
        end
    end

    // status flags; non-arithmetic operations leave them alone
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags_q <= FLAGS_RESET;
        end else if (exec_now & is_sub) begin
            flags_q <= alu.flags;                        // see RULE2 see RULE3
        end else if (wr_done & hit_stat) begin
            flags_q <= pwdata[FLAG_W-1:0];
        end
    end

    // data memory has no reset; software initialises it
    always_ff @(posedge pclk) begin
        if (exec_now & (op_q == op_minus_into_memory)) begin
            mem[addr_q] <= alu.difference;               // see RULE1
        end else if (exec_now & (op_q == op_nibble_exchange)) begin
            mem[addr_q] <= mem_swap;                     // see RULE5
        end else if (wr_done & hit_data) begin
            mem[addr_q] <= pwdata[DATA_W-1:0];
        end
    end

endmodule : subtract_swap_skip_exec

// [verification/subtract_swap_skip_checker.sv]
`timescale 1ns/10ps
module subtract_swap_skip_checker
    import subtract_swap_skip_pkg::*;
(
    input wire logic                  pclk,
    input wire logic                  presetn,
    input wire logic                  psel,
    input wire logic                  penable,
    input wire logic                  pwrite,
    input wire logic [APB_ADDR_W-1:0] paddr,
    input wire logic [APB_DATA_W-1:0] pwdata,
    input wire logic [3:0]            pstrb,
    input wire logic                  pready,
    input wire logic [APB_DATA_W-1:0] prdata,
    input wire logic                  pslverr
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire logic rd_done = pready && !pwrite;
    wire logic mapped  = (paddr <= REG_CYCLES) && (paddr[1:0] == 2'b00);

    property p_ready_in_access; pready |-> psel && penable && $past(psel && penable); endproperty
    a_ready_in_access: assert property (p_ready_in_access) else $error("pready outside access phase");
    property p_ready_pulse; pready |=> !pready; endproperty
    a_ready_pulse: assert property (p_ready_pulse) else $error("pready longer than one cycle");
    property p_err_only_ready; pslverr |-> pready; endproperty
    a_err_only_ready: assert property (p_err_only_ready) else $error("pslverr without pready");
    property p_unmapped; rd_done && !mapped |-> pslverr && prdata == '0; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not refused");
    property p_mapped_ok; pready && mapped |-> !pslverr; endproperty
    a_mapped_ok: assert property (p_mapped_ok) else $error("mapped access refused");
    property p_byte_regs;
        rd_done && (paddr == REG_WREG || paddr == REG_MEM_DATA) |-> prdata[31:8] == '0;
    endproperty
    a_byte_regs: assert property (p_byte_regs) else $error("byte register wider than eight bits");
    property p_status_layout;
        rd_done && paddr == REG_STATUS |->
            prdata[31:10] == '0 && prdata[7:6] == 2'b00 && prdata[FLAG_CHAIN_NULL] == prdata[FLAG_NULL];
    endproperty
    a_status_layout: assert property (p_status_layout) else $error("status word malformed");
    property p_instr_fields;
        rd_done && paddr == REG_INSTR |-> prdata[31:16] == '0 && !prdata[3] && !prdata[7];
    endproperty
    a_instr_fields: assert property (p_instr_fields) else $error("instruction word malformed");
    property p_answer_bound; psel && penable && !pready |-> ##[1:200] pready; endproperty
    a_answer_bound: assert property (p_answer_bound) else $error("no answer to access");
    property p_prdata_hold; $changed(prdata) |-> $past(psel && penable); endproperty
    a_prdata_hold: assert property (p_prdata_hold) else $error("read data moved without a read");

    c_busy_seen: cover property (rd_done && paddr == REG_STATUS && prdata[STATUS_BUSY_BIT]);
    c_skip_seen: cover property (rd_done && paddr == REG_STATUS && prdata[STATUS_SKIP_BIT]);
    c_refused: cover property (pready && pslverr);
endmodule : subtract_swap_skip_checker

bind subtract_swap_skip_exec subtract_swap_skip_checker i_subtract_swap_skip_checker (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr));

// [verification/tb_top.sv]
`timescale 1ns/10ps
module tb_top
    import subtract_swap_skip_pkg::*;
;
    logic                  pclk;
    logic                  presetn;
    logic                  psel;
    logic                  penable;
    logic                  pwrite;
    logic [APB_ADDR_W-1:0] paddr;
    logic [APB_DATA_W-1:0] pwdata;
    logic [3:0]            pstrb;
    logic                  pready;
    logic [APB_DATA_W-1:0] prdata;
    logic                  pslverr;
    int                    err_count;
    int                    n_checks;

    subtract_swap_skip_exec i_subtract_swap_skip_exec (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr));

    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end

    task automatic close_out();
        if (err_count == 0 && n_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : close_out

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk

    // request held until pready is sampled high, then released
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
                       output logic e);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 500);
        if (pready !== 1'b1) begin
            err_count++;
            $display("ERROR %0t no pready on access", $time);
        end
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // packs {skip, flags, memory byte, working register}
    function automatic logic [22:0] expect_f(input logic [2:0] op, input logic [7:0] w, input logic [7:0] m,
                                             input logic [7:0] imm, input logic [2:0] bi, input logic [5:0] fl);
        logic [7:0] b, r, nw, nm;
        logic       sk, ov;
        b = (op == op_minus_immediate) ? imm : m;
        r = w - b; nw = w; nm = m; sk = 1'b0;
        ov = (w[7] != b[7]) && (r[7] != w[7]);
        case (op)
            op_minus_into_wreg, op_minus_immediate: nw = r;
            op_minus_into_memory: nm = r;
            op_nibble_exchange: nm = {m[3:0], m[7:4]};
            op_nibble_exchange_to_wreg: nw = {m[3:0], m[7:4]};
            op_skip_if_null: sk = (m == 8'h00);
            op_load_and_skip_if_null: begin
                nw = m;
                sk = (m == 8'h00);
            end
            default: sk = !m[bi];
        endcase
        if (op <= 3'd2) fl = {r == 8'h00, ov ^ r[7], ov, w[3:0] >= b[3:0], w >= b, r == 8'h00};
        return {sk, fl, nm, nw};
    endfunction : expect_f

    task automatic run_one(input logic [2:0] op, input logic [7:0] w, input logic [7:0] m, input logic [7:0] imm,
                           input logic [2:0] bi, input logic [5:0] fl, input logic [5:0] ad);
        logic [31:0] q, c0;
        logic        e;
        logic [22:0] x;
        int          n;
        x = expect_f(op, w, m, imm, bi, fl);
        apb(1'b1, REG_WREG, {24'h0, w}, q, e);
        apb(1'b1, REG_MEM_ADDR, {26'h0, ad}, q, e);
        apb(1'b1, REG_MEM_DATA, {24'h0, m}, q, e);
        apb(1'b1, REG_STATUS, {26'h0, fl}, q, e);
        apb(1'b0, REG_CYCLES, 32'h0, c0, e);
        apb(1'b1, REG_INSTR, {16'h0, imm, 1'b0, bi, 1'b0, op}, q, e);
        n = 0;
        q = 32'h100;
        while (q[STATUS_BUSY_BIT] !== 1'b0 && n < 100) begin
            apb(1'b0, REG_STATUS, 32'h0, q, e);
            n++;
        end
        chk(q, {22'h0, x[22], 3'b000, x[21:16]}, "status");
        apb(1'b0, REG_INSTR, 32'h0, q, e);
        chk(q, {16'h0, imm, 1'b0, bi, 1'b0, op}, "instruction word");
        apb(1'b0, REG_WREG, 32'h0, q, e);
        chk(q, {24'h0, x[7:0]}, "working register");
        apb(1'b0, REG_MEM_DATA, 32'h0, q, e);
        chk(q, {24'h0, x[15:8]}, "memory byte");
        apb(1'b0, REG_CYCLES, 32'h0, q, e);
        chk(q - c0, (op >= 3'd5) ? 32'h2 : 32'h1, "instruction cycles");
    endtask : run_one

    initial begin
        #200000;
        err_count++;
        close_out();
    end

    initial begin
        logic [31:0] q;
        logic        e;
        logic [7:0]  w, m;
        logic [5:0]  f;
        psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0; pstrb = 4'hf;
        presetn = 1'b0; err_count = 0; n_checks = 0;
        void'($urandom(93363));
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, REG_STATUS, 32'h0, q, e);
        chk(q, 32'h0, "status after reset");
        apb(1'b0, 8'h18, 32'h0, q, e);
        chk({31'h0, e}, 32'h1, "unmapped refused");
        // lane 0 off: the whole write must be ignored
        pstrb <= 4'he;
        apb(1'b1, REG_WREG, 32'h000000a5, q, e);
        pstrb <= 4'hf;
        apb(1'b0, REG_WREG, 32'h0, q, e);
        chk(q, 32'h0, "write without lane 0 ignored");
        // first eight force a zero byte, next eight equal operands
        for (int k = 0; k < 64; k++) begin
            w = 8'($urandom);
            m = (k < 8) ? 8'h00 : (k < 16) ? w : 8'($urandom);
            // preset flags keep chained_null equal to result_null, as a lone subtraction leaves them
            f = 6'($urandom);
            f[5] = f[0];
            run_one(3'(k % 8), w, m, 8'($urandom), 3'($urandom), f, 6'($urandom));
        end
        close_out();
    end
endmodule : tb_top
